// ### prio_level_defs.vh
/*
 * constants for the priority level configuration block:
 * register offsets, field positions, reset values.
 * assumes a classic wishbone slave with 32-bit data, byte addresses.
 */
`ifndef PRIO_LEVEL_DEFS_VH
`define PRIO_LEVEL_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte address, word aligned)
// ----------------------------------------------------------------------
`define ADDR_W 8
`define OFS_CPU_CTRL 8'h00
`define OFS_SRC_PRIO_BASE 8'h10
`define SRC_REG_COUNT 12
`define SRC_IDX_W 4

// ----------------------------------------------------------------------
// cpu priority control register fields
// ----------------------------------------------------------------------
`define CPU_CTRL_ENABLE_BIT 7
`define CPU_CTRL_XFER_HI 6
`define CPU_CTRL_XFER_LO 4
`define CPU_CTRL_AUTO_BIT 3
`define CPU_CTRL_LEVEL_HI 2
`define CPU_CTRL_LEVEL_LO 0
`define CPU_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// source priority register layout
// ----------------------------------------------------------------------
`define SRC_PRIO_RESET 16'h7777
`define SRC_PRIO_WMASK 16'h7777
`define LEVEL_LOWEST 3'h0
`define LEVEL_HIGHEST 3'h7

// ----------------------------------------------------------------------
// interrupt control modes
// ----------------------------------------------------------------------
`define MODE_SINGLE_BIT 2'h0
`define MODE_THREE_BIT 2'h2

`endif

// ### level_arbiter.v
/*
 * cpu versus transfer/dma controller priority arbitration.
 * assumes levels come from registers on the same clock.
 */
`include "prio_level_defs.vh"
module level_arbiter (
    // levels
    input wire ctrlEnable,
    input wire [2:0] cpuLevel,
    input wire [2:0] xferLevel,
    input wire [2:0] dmaLevel,
    // requests
    input wire xferReq,
    input wire dmaReq,
    input wire cpuReq,
    // grants
    output reg cpuWins,
    output reg [2:0] cpuEffLevel
);
    always @* begin
        cpuEffLevel = ctrlEnable ? cpuLevel : `LEVEL_LOWEST;
        // R8 cpu lowest
        if (!ctrlEnable) begin
            cpuWins = cpuReq & ~xferReq & ~dmaReq;
        // R11 higher level wins
        end else begin
            cpuWins = cpuReq
                & (~xferReq | (cpuLevel > xferLevel))
                & (~dmaReq | (cpuLevel > dmaLevel));
        end
    end
endmodule

// ### priority_level_config.v
/*
 * priority level configuration: cpu priority control register,
 * source priority registers and cpu-versus-controller grant.
 * assumes a classic wishbone master on mclk, synchronous reset.
 */
// Summary of operation
// R1 - 3-bit cpu level field, 000 lowest to 111 highest, resets to 000.
// R2 - enable bit set: cpu ranked against controllers at its level field.
// R3 - auto bit set: hardware sets cpu level, software writes ignored.
// R4 - every source but nmi and sleep gets a level 0 to 7.
// R5 - each 16-bit source register holds four 3-bit level fields.
// R6 - level codes: 000 lowest, 111 highest, higher code wins.
// R7 - bits 15, 11, 7, 3 read zero and ignore writes.
// R8 - enable bit clear: cpu always lowest against controllers.
// R9 - auto bit set: cpu mask value copied into cpu level field.
// R10 - 3-bit transfer controller level field, 000 lowest, 111 highest.
// R11 - enabled: higher of cpu and requesting controller is granted.
`include "prio_level_defs.vh"
module priority_level_config (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`ADDR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // cpu mask and mode
    input wire [1:0] intCtrlMode,
    input wire cpuMaskBit,
    input wire [2:0] cpuMaskLevel,
    // arbitration
    input wire [2:0] dmaLevel,
    input wire xferReq,
    input wire dmaReq,
    input wire cpuReq,
    output reg cpuGrant_q,
    output reg [2:0] cpuEffLevel_q,
    // source levels, four per register
    output reg [`SRC_REG_COUNT*16-1:0] srcLevels_q
);
    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    reg [7:0] cpuCtrl_q;
    reg [15:0] srcPrio_q [0:`SRC_REG_COUNT-1];
    integer i;
    integer k;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrStb = access & wb_we_i;
    wire selCtrl = (wb_adr_i == `OFS_CPU_CTRL);
    wire [`ADDR_W-1:0] srcOfs = wb_adr_i - `OFS_SRC_PRIO_BASE;
    wire selSrc = (wb_adr_i >= `OFS_SRC_PRIO_BASE)
        && (srcOfs[`ADDR_W-1:2] < `SRC_REG_COUNT)
        && (wb_adr_i[1:0] == 2'h0);
    wire [`SRC_IDX_W-1:0] srcIdx = srcOfs[`SRC_IDX_W+1:2];

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire ctrlEnable = cpuCtrl_q[`CPU_CTRL_ENABLE_BIT];
    wire autoLevel = cpuCtrl_q[`CPU_CTRL_AUTO_BIT];
    wire [2:0] cpuLevel = cpuCtrl_q[`CPU_CTRL_LEVEL_HI:`CPU_CTRL_LEVEL_LO];
    // R10 transfer level field
    wire [2:0] xferLevel = cpuCtrl_q[`CPU_CTRL_XFER_HI:`CPU_CTRL_XFER_LO];
    wire levelWritable = !autoLevel && !wb_dat_i[`CPU_CTRL_AUTO_BIT];

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [2:0] maskToLevel;
        input [1:0] mode;
        input bitMask;
        input [2:0] lvlMask;
        begin
            if (mode == `MODE_THREE_BIT) begin
                maskToLevel = lvlMask;
            end else begin
                maskToLevel = {3{bitMask}};
            end
        end
    endfunction

    function [15:0] mergeBytes;
        input [15:0] old;
        input [15:0] wdat;
        input [1:0] sel;
        begin
            mergeBytes = old;
            if (sel[0]) begin
                mergeBytes[7:0] = wdat[7:0];
            end
            if (sel[1]) begin
                mergeBytes[15:8] = wdat[15:8];
            end
        end
    endfunction

    function [31:0] readWord;
        input isCtrl;
        input isSrc;
        input [7:0] ctrlVal;
        input [15:0] srcVal;
        begin
            if (isCtrl) begin
                readWord = {24'h000000, ctrlVal};
            end else if (isSrc) begin
                readWord = {16'h0000, srcVal};
            end else begin
                readWord = 32'h00000000;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // cpu priority control register
    // ------------------------------------------------------------------
    reg [7:0] cpuCtrl_d;
    always @* begin
        cpuCtrl_d = cpuCtrl_q;
        if (wrStb && selCtrl && wb_sel_i[0]) begin
            cpuCtrl_d[7:3] = wb_dat_i[7:3];
            // R3 ignore level writes
            if (levelWritable) begin
                cpuCtrl_d[2:0] = wb_dat_i[2:0];
            end
        end
        // R9 copy cpu mask
        if (cpuCtrl_d[`CPU_CTRL_AUTO_BIT]) begin
            cpuCtrl_d[2:0] = maskToLevel(intCtrlMode, cpuMaskBit,
                cpuMaskLevel);
        end
    end

    always @(posedge mclk) begin
        // R1 level resets to 000
        if (sys_rst) begin
            cpuCtrl_q <= `CPU_CTRL_RESET;
        end else begin
            cpuCtrl_q <= cpuCtrl_d;
        end
    end

    // ------------------------------------------------------------------
    // source priority registers
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            for (i = 0; i < `SRC_REG_COUNT; i = i + 1) begin
                srcPrio_q[i] <= `SRC_PRIO_RESET;
            end
        // R5 four level fields
        end else if (wrStb && selSrc) begin
            // R7 reserved bits stay zero
            srcPrio_q[srcIdx] <= mergeBytes(srcPrio_q[srcIdx],
                wb_dat_i[15:0], wb_sel_i[1:0]) & `SRC_PRIO_WMASK;
        end
    end

    // R4 levels to arbiters
    always @(posedge mclk) begin
        if (sys_rst) begin
            srcLevels_q <= {`SRC_REG_COUNT{`SRC_PRIO_RESET}};
        end else begin
            for (k = 0; k < `SRC_REG_COUNT; k = k + 1) begin
                srcLevels_q[k*16 +: 16] <= srcPrio_q[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= access;
            if (access && !wb_we_i) begin
                wb_dat_o <= readWord(selCtrl, selSrc, cpuCtrl_q,
                    srcPrio_q[srcIdx]);
            end
        end
    end

    // ------------------------------------------------------------------
    // cpu versus controller arbitration
    // ------------------------------------------------------------------
    wire cpuWins;
    wire [2:0] cpuEff;
    // R2 ranked at cpu level
    // R6 higher code wins
    // R10 transfer level field
    level_arbiter arb (
        .ctrlEnable(ctrlEnable),
        .cpuLevel(cpuLevel),
        .xferLevel(xferLevel),
        .dmaLevel(dmaLevel),
        .xferReq(xferReq),
        .dmaReq(dmaReq),
        .cpuReq(cpuReq),
        .cpuWins(cpuWins),
        .cpuEffLevel(cpuEff)
    );

    always @(posedge mclk) begin
        if (sys_rst) begin
            cpuGrant_q <= 1'b0;
            cpuEffLevel_q <= `LEVEL_LOWEST;
        end else begin
            cpuGrant_q <= cpuWins;
            cpuEffLevel_q <= cpuEff;
        end
    end
endmodule

// ### prio_cfg_assertions.sv
/* port checks for priority_level_config; assumes a bind onto it */
module prio_cfg_assertions (
    // clock and reset
    input logic mclk,
    input logic sys_rst,
    // watched ports
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic [31:0] wb_dat_o,
    input logic cpuReq,
    input logic xferReq,
    input logic dmaReq,
    input logic [2:0] dmaLevel,
    input logic cpuGrant_q,
    input logic [2:0] cpuEffLevel_q,
    input logic [191:0] srcLevels_q
);
timeunit 1ns / 1ns;
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
a_ack_pulse: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse");
a_ack_cause: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("stray ack");
a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper bits set");
a_resv_zero: assert property (!(srcLevels_q & {12{16'h8888}}))
    else $error("reserved bit set");
a_reset_vals: assert property (
    $fell(sys_rst) |-> !cpuEffLevel_q && srcLevels_q == {12{16'h7777}})
    else $error("bad reset value");
a_no_req: assert property (!cpuReq |=> !cpuGrant_q)
    else $error("grant without request");
a_alone_wins: assert property (
    cpuReq && !xferReq && !dmaReq |=> cpuGrant_q) else $error("cpu lost");
a_top_dma: assert property (
    dmaReq && dmaLevel == 3'h7 |=> !cpuGrant_q) else $error("cpu beat 7");
endmodule
bind priority_level_config prio_cfg_assertions chkInst (.mclk(mclk),
    .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cpuReq(cpuReq),
    .xferReq(xferReq), .dmaReq(dmaReq), .dmaLevel(dmaLevel),
    .cpuGrant_q(cpuGrant_q), .cpuEffLevel_q(cpuEffLevel_q),
    .srcLevels_q(srcLevels_q));

// ### priority_level_config_bench.sv
/* bench for priority_level_config; assumes the bound checker */
module priority_level_config_bench;
timeunit 1ns / 1ns;
logic mclk = 0, sys_rst = 1, cyc = 0, we = 0, ack, grant;
logic mBit = 0, xReq = 0, dReq = 0, cReq = 0;
logic [7:0] adr = 0;
logic [3:0] sel = 4'h3;
logic [31:0] wdat = 0, rdat;
logic [1:0] mode = 0;
logic [2:0] mLvl = 0, dmaLvl = 0, effLvl;
logic [191:0] src;
int err_count = 0, n_checks = 0;
priority_level_config DUT (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .intCtrlMode(mode),
    .cpuMaskBit(mBit), .cpuMaskLevel(mLvl), .dmaLevel(dmaLvl), .xferReq(xReq),
    .dmaReq(dReq), .cpuReq(cReq), .cpuGrant_q(grant), .cpuEffLevel_q(effLvl),
    .srcLevels_q(src));
initial forever #25 mclk = ~mclk;
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    err_count += int'(got !== exp);
    if (got !== exp) $display("mismatch at %0t: %h not %h", $time, got, exp);
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    repeat (20) if (ack !== 1'b1)
        @(posedge mclk);
    chk(ack, 1);
    if (ack !== 1'b1) end_of_test();
    if (!w) chk(rdat, d);
    {cyc, we} <= 2'h0;
    @(posedge mclk);
endtask
task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic testReset();
    sys_rst <= 1;
    repeat (3) @(posedge mclk);
    sys_rst <= 0;
    @(posedge mclk);
    bus(0, 8'h00, 32'h0);
    bus(0, 8'h3C, 32'h7777);
    chk(src[15:0], 16'h7777);
    $display("reset done");
endtask
task automatic testSource();
    for (int i = 0; i < 12; i++) begin
        bus(1, 8'h10 + 8'(4 * i), {16'h0, {4{1'b1, 3'(i)}}});
        bus(0, 8'h10 + 8'(4 * i), {16'h0, {4{1'b0, 3'(i)}}});
        chk(src[16 * i +: 16], {4{1'b0, 3'(i)}});
    end
    bus(1, 8'h80, 32'hFFFF);
    bus(0, 8'h80, 32'h0);
    bus(0, 8'h10, 32'h0);
    sel <= 4'h1;
    bus(1, 8'h10, 32'hFFFF);
    sel <= 4'h3;
    bus(0, 8'h10, 32'h0077);
    chk(src[15:0], 16'h0077);
    $display("source done");
endtask
task automatic testCtrl();
    {cReq, xReq} <= 2'h3;
    bus(1, 8'h00, 32'hF5);
    bus(0, 8'h00, 32'hF5);
    chk(grant, 0);
    bus(1, 8'h00, 32'h85);
    chk(grant, 1);
    chk(effLvl, 3'h5);
    bus(1, 8'h00, 32'h05);
    chk(grant, 0);
    chk(effLvl, 3'h0);
    {xReq, dReq, dmaLvl} <= 5'h0F;
    bus(1, 8'h00, 32'h87);
    chk(grant, 0);
    {mode, mLvl} <= 5'h13;
    bus(1, 8'h00, 32'h8D);
    bus(0, 8'h00, 32'h8B);
    {mode, mBit, dReq} <= 4'h2;
    repeat (2) @(posedge mclk);
    bus(0, 8'h00, 32'h8F);
    chk(grant, 1);
    chk(effLvl, 3'h7);
    $display("control done");
endtask
initial begin
    testReset();
    testSource();
    testCtrl();
    testReset();
    end_of_test();
end
endmodule
